// ===== design/kms_col_drive.v
// Column drive decode for the keypad matrix scanner
`timescale 1ns/1ps
`include "kms_regs.vh"
module kms_col_drive (
  input wire [`KMS_MODE_W-1:0] mode, // Column drive mode
  input wire [`KMS_COL_W-1:0] col_sel, // Column for single-strobe mode
  output reg [`KMS_COLS-1:0] col_val, // Level on each column
  output reg [`KMS_COLS-1:0] col_en // Drive enable per column
);
  always @* begin
    col_val = 8'h00;
    col_en = 8'h00;
    case (mode)
      `KMS_MODE_ONE: begin
        col_val[col_sel] = 1'b1;
        col_en[col_sel] = 1'b1;
      end
      `KMS_MODE_LOW: begin
        col_val = 8'h00;
        col_en = 8'hFF;
      end
      `KMS_MODE_HIGH: begin
        col_val = 8'hFF;
        col_en = 8'hFF;
      end
      default: begin
        col_val = 8'h00;
        col_en = 8'h00;
      end
    endcase
  end
endmodule // kms_col_drive

// ===== design/kms_scanner.v
// Keypad matrix scanner: column strobes and row-sense interrupt
`timescale 1ns/1ps
`include "kms_regs.vh"
module kms_scanner (
  input wire mclk, // 100 MHz clock
  input wire rst, // Synchronous reset, active high
  input wire ce, // Clock enable, freezes state when low
  input wire [`KMS_MODE_W-1:0] col_mode, // Column drive mode from control logic
  input wire [`KMS_COL_W-1:0] col_sel, // Column strobed in single mode
  input wire [`KMS_ROWS-1:0] row_int_sel, // Rows that take part in the interrupt
  input wire [`KMS_ROWS-1:0] row_sense_port, // Row pins from the matrix
  output reg [`KMS_COLS-1:0] col_out_q, // Column pin levels
  output reg [`KMS_COLS-1:0] col_oe_q, // Column pin enables, high drives
  output reg [`KMS_ROWS-1:0] row_state_q, // Synchronised row levels
  output reg kbd_irq_q, // Keyboard interrupt level
  output reg kbd_wake_async // Unclocked wake request for standby
);
  // Column drive phases share the mode encoding of the decoder
  localparam COL_ONE = `KMS_MODE_ONE;
  localparam COL_LOW = `KMS_MODE_LOW;
  localparam COL_HIGH = `KMS_MODE_HIGH;
  localparam COL_FLOAT = `KMS_MODE_FLOAT;

  // Interrupt tracker states
  localparam IRQ_IDLE = 1'b0;
  localparam IRQ_ACTIVE = 1'b1;

  reg [`KMS_MODE_W-1:0] col_state_q;
  reg [`KMS_MODE_W-1:0] col_state_d;
  reg [`KMS_COL_W-1:0] col_sel_q;
  reg [`KMS_COL_W-1:0] col_sel_d;
  wire [`KMS_COLS-1:0] drive_val;
  wire [`KMS_COLS-1:0] drive_en;

  reg [`KMS_ROWS-1:0] row_meta_q;
  reg [`KMS_ROWS-1:0] row_meta_d;
  reg [`KMS_ROWS-1:0] row_state_d;

  reg rows_hit;
  reg irq_state_q;
  reg irq_state_d;
  reg kbd_irq_d;

  function kms_any_selected;
    input [`KMS_ROWS-1:0] rows;
    input [`KMS_ROWS-1:0] mask;
    begin
      kms_any_selected = |(rows & mask);
    end
  endfunction

  // Mode is held as a phase; the decoder sees the next phase, so the
  // pins still change one edge after the request
  always @* begin
    col_state_d = col_state_q;
    col_sel_d = col_sel_q;
    if (ce) begin
      col_sel_d = col_sel;
      case (col_mode)
        `KMS_MODE_ONE: begin
          col_state_d = COL_ONE;
        end
        `KMS_MODE_LOW: begin
          col_state_d = COL_LOW;
        end
        `KMS_MODE_HIGH: begin
          col_state_d = COL_HIGH;
        end
        default: begin
          col_state_d = COL_FLOAT;
        end
      endcase
    end
  end

  // Reset leaves every column floating, so no key can short two columns
  always @(posedge mclk) begin
    if (rst) begin
      col_state_q <= `KMS_RST_MODE;
    end else begin
      col_state_q <= col_state_d;
    end
  end

  // Select is only taken with ce, like the phase
  always @(posedge mclk) begin
    if (rst) begin
      col_sel_q <= `KMS_RST_COL;
    end else begin
      col_sel_q <= col_sel_d;
    end
  end

  kms_col_drive u_drive (
    .mode(col_state_d),
    .col_sel(col_sel_d),
    .col_val(drive_val),
    .col_en(drive_en)
  );

  // Pins follow the decoded phase; floating columns show zero on both
  always @(posedge mclk) begin
    if (rst) begin
      col_out_q <= 8'h00;
    end else begin
      col_out_q <= drive_val;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      col_oe_q <= 8'h00;
    end else begin
      col_oe_q <= drive_en;
    end
  end

  // Rows are asynchronous pins: two flops before any logic but the wake path reads them
  always @* begin
    row_meta_d = row_meta_q;
    if (ce) begin
      row_meta_d = row_sense_port;
    end
  end

  always @* begin
    row_state_d = row_state_q;
    if (ce) begin
      row_state_d = row_meta_q;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      row_meta_q <= 8'h00;
    end else begin
      row_meta_q <= row_meta_d;
    end
  end

  // Second stage; the only one that logic may read
  always @(posedge mclk) begin
    if (rst) begin
      row_state_q <= 8'h00;
    end else begin
      row_state_q <= row_state_d;
    end
  end

  // Only the second stage feeds the interrupt, at one edge more latency
  always @* begin
    rows_hit = kms_any_selected(row_state_q, row_int_sel);
  end

  // Level tracker, no sticky flag: it follows the selected rows
  always @* begin
    irq_state_d = irq_state_q;
    if (ce) begin
      case (irq_state_q)
        IRQ_IDLE: begin
          if (rows_hit) begin
            irq_state_d = IRQ_ACTIVE;
          end
        end
        IRQ_ACTIVE: begin
          if (!rows_hit) begin
            irq_state_d = IRQ_IDLE;
          end
        end
        default: begin
          irq_state_d = IRQ_IDLE;
        end
      endcase
    end
  end

  always @* begin
    case (irq_state_d)
      IRQ_ACTIVE: begin
        kbd_irq_d = 1'b1;
      end
      default: begin
        kbd_irq_d = 1'b0;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      irq_state_q <= IRQ_IDLE;
    end else begin
      irq_state_q <= irq_state_d;
    end
  end

  // Output copy of the tracker, so the pin comes straight from a flop
  always @(posedge mclk) begin
    if (rst) begin
      kbd_irq_q <= 1'b0;
    end else begin
      kbd_irq_q <= kbd_irq_d;
    end
  end

  // Standby stops mclk, so the wake path cannot wait for the synchroniser;
  // it reads the raw pins and is kept combinational on purpose
  always @* begin
    kbd_wake_async = kms_any_selected(row_sense_port, row_int_sel);
  end
endmodule // kms_scanner

// ===== include/kms_regs.vh
// Constants for the keypad matrix scanner
`ifndef KMS_REGS_VH
`define KMS_REGS_VH
`define KMS_COLS 8
`define KMS_ROWS 8
`define KMS_COL_W 3
`define KMS_MODE_W 2
`define KMS_MODE_ONE 2'h0
`define KMS_MODE_LOW 2'h1
`define KMS_MODE_HIGH 2'h2
`define KMS_MODE_FLOAT 2'h3
`define KMS_RST_MODE 2'h3
`define KMS_RST_COL 3'h0
`define KMS_RST_SEL 8'hFF
`endif

// ===== tb/kms_keys.sv
// Passive key switch matrix, rows pulled low
`timescale 1ns/1ps
module kms_keys(input wire [7:0] col_out_q,col_oe_q,input wire [63:0] key,output reg [7:0] row);
integer r;
always @* for(r=0;r<8;r=r+1) row[r]=|(key[r*8+:8]&col_out_q&col_oe_q);
endmodule // kms_keys

// ===== tb/kms_scanner_sva.sv
// Assertions for the keypad matrix scanner
`timescale 1ns/1ps
module kms_sva(input wire mclk,rst,ce,kbd_irq_q,kbd_wake_async,input wire [1:0] col_mode,
input wire [2:0] col_sel,input wire [7:0] col_out_q,col_oe_q,row_int_sel,row_sense_port);
default clocking @(posedge mclk);endclocking
default disable iff(rst);
wire hit=|(row_sense_port&row_int_sel);
a_one_col: assert property(ce&&col_mode==2'h0|=>col_oe_q==8'h01<<$past(col_sel))else $error("c");
a_col_onehot: assert property(col_oe_q!=8'hFF|->$onehot0(col_oe_q)&&col_out_q==col_oe_q)else $error("h");
a_all_low: assert property(ce&&col_mode==2'h1|=>col_oe_q==8'hFF&&col_out_q==8'h00)else $error("l");
a_all_high: assert property(ce&&col_mode==2'h2|=>col_out_q==8'hFF&&col_oe_q==8'hFF)else $error("g");
a_all_float: assert property(ce&&col_mode==2'h3|=>col_oe_q==8'h00)else $error("f");
a_wake_or: assert property(kbd_wake_async==hit)else $error("w");
a_irq_set: assert property((ce&&hit)[*4]|->kbd_irq_q)else $error("i");
a_irq_clear: assert property((ce&&!hit)[*4]|->!kbd_irq_q)else $error("n");
a_ce_hold: assert property(!ce|=>$stable(col_oe_q)&&$stable(col_out_q)&&$stable(kbd_irq_q))else $error("e");
c_irq: cover property(kbd_irq_q);
c_one: cover property(col_oe_q==8'h20);
c_low: cover property(col_oe_q==8'hFF&&col_out_q==8'h00);
c_hold: cover property(!ce&&kbd_wake_async);
endmodule // kms_sva
bind kms_scanner kms_sva kms_sva_i(.mclk,.rst,.ce,.kbd_irq_q,.kbd_wake_async,.col_mode,.col_sel,
.col_out_q,.col_oe_q,.row_int_sel,.row_sense_port);

// ===== tb/tb_kms_scanner.sv
// Bench for the keypad matrix scanner
`timescale 1ns/1ps
module tb_kms_scanner;
reg mclk=0,rst=1,ce=1;reg [1:0] col_mode=2'h3;reg [2:0] col_sel=3'h0;reg [7:0] row_int_sel=8'hFF;
reg [63:0] key=64'h0;wire [7:0] col_out_q,col_oe_q,row_state_q,row_sense_port;
wire kbd_irq_q,kbd_wake_async;integer errors=0,comparisons=0,i;
kms_scanner kms_scanner_i(.mclk,.rst,.ce,.col_mode,.col_sel,.row_int_sel,.row_sense_port,
.col_out_q,.col_oe_q,.row_state_q,.kbd_irq_q,.kbd_wake_async);
kms_keys kms_keys_i(.col_out_q,.col_oe_q,.key,.row(row_sense_port));
task chk(input [63:0] n,input [7:0] e,v);begin comparisons=comparisons+1;
if(v!==e)begin errors=errors+1;$display("wrong value %0s exp %h got %h",n,e,v);end end endtask
task step(input integer k);begin repeat(k)@(posedge mclk);#1;end endtask
task t_cols;for(i=0;i<8;i=i+1)begin col_mode=2'h0;col_sel=i[2:0];step(1);
chk("col",8'h01<<i,col_out_q);chk("oe",8'h01<<i,col_oe_q);
end endtask
task t_modes;for(i=1;i<4;i=i+1)begin col_mode=i[1:0];step(1);
chk("oe",i<3?8'hFF:8'h00,col_oe_q);chk("col",i==2?8'hFF:8'h00,col_out_q);
end endtask
task t_keys;begin col_mode=2'h2;key=64'h1<<21;row_int_sel=8'h04;step(4);
chk("irq",1,kbd_irq_q);chk("wake",1,kbd_wake_async);
row_int_sel=8'hFB;step(3);chk("wake",0,kbd_wake_async);chk("irq",0,kbd_irq_q);
col_mode=2'h0;col_sel=3'h5;step(4);chk("rows",8'h04,row_state_q);
col_sel=3'h4;step(4);chk("rows",0,row_state_q);key=64'h0;end endtask
task t_hold;begin ce=0;col_mode=2'h1;key=64'h1<<20;row_int_sel=8'h04;step(4);
chk("hcol",8'h10,col_out_q);chk("hirq",0,kbd_irq_q);chk("hwake",1,kbd_wake_async);
ce=1;step(4);chk("oe",8'hFF,col_oe_q);chk("col",0,col_out_q);chk("irq",0,kbd_irq_q);
key=64'h0;end endtask
task t_reset;begin col_mode=2'h2;key=64'h1<<20;step(4);chk("irq",1,kbd_irq_q);
rst=1;step(2);chk("rst",0,col_oe_q);chk("rirq",0,kbd_irq_q);chk("rrow",0,row_state_q);
rst=0;col_mode=2'h3;key=64'h0;step(1);chk("oe",0,col_oe_q);end endtask
task results;begin $display("errors %0d comparisons %0d",errors,comparisons);
if(errors==0&&comparisons>0)$display("Finished cleanly");
else $display("Finished with errors");
$finish;end endtask
initial forever #5 mclk=~mclk;
initial begin #20000;errors=errors+1;results;end
initial begin step(5);rst=0;chk("rst",0,col_oe_q);t_cols;t_modes;t_keys;t_hold;t_reset;results;end
endmodule // tb_kms_scanner
